// [rtl/laldec_core.v]
`timescale 1ns/1ps
`include "laldec_map.vh"
// Function
// - add_literal_to_acc adds literal, sets all flags
// - and_literal_to_acc ANDs, sets zero and negative
// - or_literal_to_acc ORs, sets zero and negative
// - xor_literal_to_acc XORs, sets zero and negative
// - literal_minus_acc subtracts accumulator, all flags
// - load_literal_acc loads literal, flags untouched
// - load_literal_bank loads bank low nibble
// - multiply_literal_acc multiplies, flags untouched
// - return_with_literal loads accumulator, two cycles
// - load_pointer_literal two words form 12-bit pointer
// - table_read_op two cycles, four pointer modes
// - table_write_op two cycles, pointer modes
// - Program counter change adds a no-operation cycle
// - Lone second word executes as no-operation
// - Port read-modify-write sources pin levels
// - Timer count write clears assigned prescaler
// - add_acc_to_file_reg adds, d selects destination
// - Access bit selects access or banked
// - Extended set, low address uses indexed
module laldec_core (
  input wire clock,
  input wire srst,
  input wire [15:0] instr_word,
  input wire ext_set_en,
  input wire [7:0] file_rdata,
  input wire file_is_port,
  input wire [7:0] port_pins,
  input wire file_is_timer_zero,
  input wire prescaler_to_timer,
  input wire [7:0] index_base,
  output wire [1:0] phase,
  output reg fetch_next_q,
  output reg [11:0] file_raddr_q,
  output reg file_raddr_indexed_q,
  output reg file_we_q,
  output reg [11:0] file_waddr_q,
  output reg [7:0] file_wdata_q,
  output reg [7:0] working_accumulator_q,
  output reg [4:0] status_flags_q,
  output reg [3:0] bank_select_reg_q,
  output reg [15:0] product_q,
  output reg [11:0] file_select_pointer0_q,
  output reg [11:0] file_select_pointer1_q,
  output reg [11:0] file_select_pointer2_q,
  output reg [20:0] table_ptr_q,
  output reg table_read_q,
  output reg table_write_q,
  output reg return_pop_q,
  output reg prescaler_clear_q
);
  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  localparam PH_DECODE = 2'h0;
  localparam PH_READ = 2'h1;
  localparam PH_PROCESS = 2'h2;
  localparam PH_WRITE = 2'h3;
  // Decoded operation kinds, held over one instruction cycle.
  localparam OP_NOP = 4'h0;
  localparam OP_ADDL = 4'h1;
  localparam OP_ANDL = 4'h2;
  localparam OP_ORL = 4'h3;
  localparam OP_XORL = 4'h4;
  localparam OP_SUBL = 4'h5;
  localparam OP_MOVL = 4'h6;
  localparam OP_BANK = 4'h7;
  localparam OP_MUL = 4'h8;
  localparam OP_RETL = 4'h9;
  localparam OP_PTR1 = 4'hA;
  localparam OP_TRD = 4'hB;
  localparam OP_TWR = 4'hC;
  localparam OP_ADDF = 4'hD;

  reg [3:0] op_q;
  reg [3:0] op_d;
  reg [7:0] lit_q;
  reg dest_file_q;
  reg [1:0] tbl_mode_q;
  reg [1:0] ptr_sel_q;
  reg [3:0] ptr_hi_q;
  reg ptr_pending_q;
  reg extra_cycle_q;
  reg [7:0] operand_q;
  reg [7:0] result_q;
  reg [4:0] result_flags_q;
  reg [11:0] file_addr_d;
  reg indexed_d;
  reg [7:0] pins_s1_q, pins_s2_q, pins_s3_q, pins_q;
  wire [7:0] alu_a;
  wire [7:0] alu_b;
  wire alu_sub;
  wire [7:0] alu_sum;
  wire [4:0] alu_flags;
  wire [7:0] logic_res;
  wire is_second_word;

  laldec_phase u_phase (
    .clock(clock),
    .srst(srst),
    .phase_q(phase)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign is_second_word = (instr_word[15:12] == `LALDEC_SECOND_WORD);

  // Opcode decode; an unrecognised word becomes a no-operation.
  always @* begin
    op_d = OP_NOP;
    if (is_second_word) begin
      op_d = OP_NOP;
    end else if (instr_word[15:8] == `LALDEC_OP_ADD_LIT) begin
      op_d = OP_ADDL;
    end else if (instr_word[15:8] == `LALDEC_OP_AND_LIT) begin
      op_d = OP_ANDL;
    end else if (instr_word[15:8] == `LALDEC_OP_OR_LIT) begin
      op_d = OP_ORL;
    end else if (instr_word[15:8] == `LALDEC_OP_XOR_LIT) begin
      op_d = OP_XORL;
    end else if (instr_word[15:8] == `LALDEC_OP_SUB_LIT) begin
      op_d = OP_SUBL;
    end else if (instr_word[15:8] == `LALDEC_OP_LOAD_LIT) begin
      op_d = OP_MOVL;
    end else if (instr_word[15:4] == `LALDEC_OP_LOAD_BANK) begin
      op_d = OP_BANK;
    end else if (instr_word[15:8] == `LALDEC_OP_MUL_LIT) begin
      op_d = OP_MUL;
    end else if (instr_word[15:8] == `LALDEC_OP_RET_LIT) begin
      op_d = OP_RETL;
    end else if (instr_word[15:6] == `LALDEC_OP_PTR_W1) begin
      op_d = OP_PTR1;
    end else if (instr_word[15:2] == `LALDEC_OP_TBL) begin
      op_d = OP_TRD;
    end else if (instr_word[15:2] == (`LALDEC_OP_TBL | 14'h0001)) begin
      op_d = OP_TWR;
    end else if (instr_word[15:10] == `LALDEC_OP_ADD_FILE) begin
      op_d = OP_ADDF;
    end
  end

  always @* begin
    indexed_d = 1'b0;
    if (!instr_word[8] && ext_set_en && (instr_word[7:0] <= `LALDEC_INDEXED_MAX)) begin
      indexed_d = 1'b1;
      file_addr_d = {4'h0, index_base + instr_word[7:0]};
    end else if (!instr_word[8]) begin
      file_addr_d = {{4{instr_word[7]}}, instr_word[7:0]};
    end else begin
      file_addr_d = {bank_select_reg_q, instr_word[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // Execution datapath
  // ----------------------------------------------------------------
  // literal minus accumulator
  assign alu_sub = (op_q == OP_SUBL);
  assign alu_a = lit_q;
  assign alu_b = (op_q == OP_ADDF) ? operand_q : working_accumulator_q;
  laldec_alu u_alu (
    .a((op_q == OP_ADDF) ? working_accumulator_q : alu_a),
    .b(alu_b),
    .sub(alu_sub),
    .sum(alu_sum),
    .flags(alu_flags)
  );
  assign logic_res = (op_q == OP_ANDL) ? (lit_q & working_accumulator_q) :
                     (op_q == OP_ORL) ? (lit_q | working_accumulator_q) :
                     (lit_q ^ working_accumulator_q);

  // pin level synchroniser
  // A bit moves only once stages two and three agree, so a one-clock glitch never reaches the operand.
  always @(posedge clock) begin
    pins_s1_q <= port_pins;
    pins_s2_q <= pins_s1_q;
    pins_s3_q <= pins_s2_q;
    pins_q <= (pins_s2_q & pins_s3_q) | (pins_q & (pins_s2_q | pins_s3_q));
  end

  always @(posedge clock) begin
    if (srst) begin
      op_q <= OP_NOP;
      lit_q <= 8'h00;
      dest_file_q <= 1'b0;
      tbl_mode_q <= `LALDEC_TBL_NONE;
      ptr_sel_q <= 2'h0;
      ptr_hi_q <= 4'h0;
      ptr_pending_q <= 1'b0;
      extra_cycle_q <= 1'b0;
      operand_q <= 8'h00;
      result_q <= 8'h00;
      result_flags_q <= `LALDEC_FLAGS_RESET;
      fetch_next_q <= 1'b0;
      file_raddr_q <= 12'h000;
      file_raddr_indexed_q <= 1'b0;
      file_we_q <= 1'b0;
      file_waddr_q <= 12'h000;
      file_wdata_q <= 8'h00;
      working_accumulator_q <= `LALDEC_ACC_RESET;
      status_flags_q <= `LALDEC_FLAGS_RESET;
      bank_select_reg_q <= `LALDEC_BANK_RESET;
      product_q <= 16'h0000;
      file_select_pointer0_q <= `LALDEC_PTR_RESET;
      file_select_pointer1_q <= `LALDEC_PTR_RESET;
      file_select_pointer2_q <= `LALDEC_PTR_RESET;
      table_ptr_q <= `LALDEC_TBLPTR_RESET;
      table_read_q <= 1'b0;
      table_write_q <= 1'b0;
      return_pop_q <= 1'b0;
      prescaler_clear_q <= 1'b0;
    end else begin
      file_we_q <= 1'b0;
      fetch_next_q <= 1'b0;
      table_read_q <= 1'b0;
      table_write_q <= 1'b0;
      return_pop_q <= 1'b0;
      prescaler_clear_q <= 1'b0;
      case (phase)
        PH_DECODE: begin
          if (extra_cycle_q) begin
            op_q <= OP_NOP;
            extra_cycle_q <= 1'b0;
          end else if (ptr_pending_q) begin
            op_q <= OP_NOP;
            ptr_pending_q <= 1'b0;
            if (instr_word[15:8] == `LALDEC_OP_PTR_W2) begin
              case (ptr_sel_q)
                2'h0: file_select_pointer0_q <= {ptr_hi_q, instr_word[7:0]};
                2'h1: file_select_pointer1_q <= {ptr_hi_q, instr_word[7:0]};
                default: file_select_pointer2_q <= {ptr_hi_q, instr_word[7:0]};
              endcase
            end
          end else begin
            op_q <= op_d;
            lit_q <= instr_word[7:0];
            dest_file_q <= instr_word[9];
            tbl_mode_q <= instr_word[1:0];
            ptr_sel_q <= instr_word[5:4];
            ptr_hi_q <= instr_word[3:0];
            file_raddr_q <= file_addr_d;
            file_raddr_indexed_q <= indexed_d;
          end
        end
        PH_READ: begin
          operand_q <= file_is_port ? pins_q : file_rdata;
        end
        PH_PROCESS: begin
          if ((op_q == OP_ANDL) || (op_q == OP_ORL) || (op_q == OP_XORL)) begin
            result_q <= logic_res;
            result_flags_q <= status_flags_q;
            result_flags_q[`LALDEC_FLAG_Z] <= (logic_res == 8'h00);
            result_flags_q[`LALDEC_FLAG_N] <= logic_res[7];
          end else begin
            result_q <= alu_sum;
            result_flags_q <= alu_flags;
          end
          if (op_q == OP_MUL) begin
            product_q <= lit_q * working_accumulator_q;
          end
        end
        default: begin
          fetch_next_q <= 1'b1;
          case (op_q)
            OP_ADDL, OP_SUBL: begin
              working_accumulator_q <= result_q;
              status_flags_q <= result_flags_q;
            end
            OP_ANDL, OP_ORL, OP_XORL: begin
              working_accumulator_q <= result_q;
              status_flags_q <= result_flags_q;
            end
            OP_MOVL: working_accumulator_q <= lit_q;
            OP_BANK: bank_select_reg_q <= lit_q[3:0];
            OP_RETL: begin
              working_accumulator_q <= lit_q;
              return_pop_q <= 1'b1;
              extra_cycle_q <= 1'b1;
            end
            OP_PTR1: ptr_pending_q <= 1'b1;
            OP_TRD, OP_TWR: begin
              table_read_q <= (op_q == OP_TRD);
              table_write_q <= (op_q == OP_TWR);
              extra_cycle_q <= 1'b1;
              case (tbl_mode_q)
                `LALDEC_TBL_POSTINC: table_ptr_q <= table_ptr_q + 21'h000001;
                `LALDEC_TBL_POSTDEC: table_ptr_q <= table_ptr_q - 21'h000001;
                `LALDEC_TBL_PREINC: table_ptr_q <= table_ptr_q + 21'h000001;
                default: table_ptr_q <= table_ptr_q;
              endcase
            end
            OP_ADDF: begin
              status_flags_q <= result_flags_q;
              if (dest_file_q) begin
                file_we_q <= 1'b1;
                file_waddr_q <= file_raddr_q;
                file_wdata_q <= result_q;
                prescaler_clear_q <= file_is_timer_zero && prescaler_to_timer;
              end else begin
                working_accumulator_q <= result_q;
              end
            end
            default: working_accumulator_q <= working_accumulator_q;
          endcase
        end
      endcase
    end
  end
endmodule

// [shared/laldec_map.vh]
`ifndef LALDEC_MAP_VH
`define LALDEC_MAP_VH
// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define LALDEC_OP_HI 15
`define LALDEC_OP_LO 8
`define LALDEC_OP_ADD_LIT 8'h0F
`define LALDEC_OP_AND_LIT 8'h0B
`define LALDEC_OP_OR_LIT 8'h09
`define LALDEC_OP_XOR_LIT 8'h0A
`define LALDEC_OP_SUB_LIT 8'h08
`define LALDEC_OP_LOAD_LIT 8'h0E
`define LALDEC_OP_LOAD_BANK 12'h010
`define LALDEC_OP_MUL_LIT 8'h0D
`define LALDEC_OP_RET_LIT 8'h0C
`define LALDEC_OP_PTR_W1 10'h3B8
`define LALDEC_OP_PTR_W2 8'hF0
`define LALDEC_OP_TBL 14'h0002
`define LALDEC_OP_ADD_FILE 6'h09
`define LALDEC_SECOND_WORD 4'hF
// ----------------------------------------------------------------
// Table pointer modes and addressing
// ----------------------------------------------------------------
`define LALDEC_TBL_NONE 2'h0
`define LALDEC_TBL_POSTINC 2'h1
`define LALDEC_TBL_POSTDEC 2'h2
`define LALDEC_TBL_PREINC 2'h3
`define LALDEC_INDEXED_MAX 8'h5F
`define LALDEC_ACC_RESET 8'h00
`define LALDEC_FLAGS_RESET 5'h00
`define LALDEC_BANK_RESET 4'h0
`define LALDEC_TBLPTR_RESET 21'h000000
`define LALDEC_PTR_RESET 12'h000
// Flag bit positions in the status vector.
`define LALDEC_FLAG_C 0
`define LALDEC_FLAG_DC 1
`define LALDEC_FLAG_Z 2
`define LALDEC_FLAG_OV 3
`define LALDEC_FLAG_N 4
`endif

// [rtl/laldec_phase.v]
`timescale 1ns/1ps
// Four-phase sequencer: one instruction cycle spans four clocks.
module laldec_phase (
  input wire clock,
  input wire srst,
  output reg [1:0] phase_q
);
  // Phase advances every clock and wraps after the fourth.
  always @(posedge clock) begin
    if (srst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
endmodule

// [rtl/laldec_alu.v]
`timescale 1ns/1ps
`include "laldec_map.vh"
// Adder with flag generation for add and subtract.
module laldec_alu (
  input wire [7:0] a,
  input wire [7:0] b,
  input wire sub,
  output wire [7:0] sum,
  output wire [4:0] flags
);
  wire [7:0] b_eff;
  wire [8:0] full;
  wire [4:0] low;
  // Subtract adds the inverted operand plus one; carry is not-borrow.
  assign b_eff = sub ? ~b : b;
  assign full = {1'b0, a} + {1'b0, b_eff} + {8'h00, sub};
  assign low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
  assign sum = full[7:0];
  assign flags[`LALDEC_FLAG_C] = full[8];
  assign flags[`LALDEC_FLAG_DC] = low[4];
  assign flags[`LALDEC_FLAG_Z] = (full[7:0] == 8'h00);
  assign flags[`LALDEC_FLAG_OV] = (a[7] == b_eff[7]) && (full[7] != a[7]);
  assign flags[`LALDEC_FLAG_N] = full[7];
endmodule

// [verification/laldec_core_chk.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Timing checker for the decoder core
// ----------------------------------------------------------------
module laldec_core_chk (
  input wire clock,
  input wire srst,
  input wire ext_set_en,
  input wire file_is_timer_zero,
  input wire prescaler_to_timer,
  input wire [1:0] phase,
  input wire fetch_next_q,
  input wire file_raddr_indexed_q,
  input wire file_we_q,
  input wire [7:0] working_accumulator_q,
  input wire [4:0] status_flags_q,
  input wire table_read_q,
  input wire table_write_q,
  input wire return_pop_q,
  input wire prescaler_clear_q
);
  // One clock domain, so clock and reset are stated once for all.
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // A two-cycle op spans eight clocks, so its pulse cannot repeat sooner.
  sequence s_quiet(sig);
    !sig [*7];
  endsequence
  // After a fetch pulse three silent clocks follow before the next one.
  sequence s_fetch_gap;
    !fetch_next_q [*3];
  endsequence
  property p_phase_step;
    $past(!srst) |-> phase == $past(phase) + 2'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance by one");
  property p_fetch;
    fetch_next_q |-> phase == 2'h0 ##1 s_fetch_gap;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch pulse out of place");
  property p_acc_update;
    $past(!srst) && (working_accumulator_q != $past(working_accumulator_q)) |-> phase == 2'h0;
  endproperty
  a_acc_update: assert property (p_acc_update) else $error("accumulator changed mid cycle");
  property p_flag_update;
    $past(!srst) && (status_flags_q != $past(status_flags_q)) |-> phase == 2'h0;
  endproperty
  a_flag_update: assert property (p_flag_update) else $error("flags changed mid cycle");
  property p_we_pulse;
    file_we_q |=> !file_we_q;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe longer than one clock");
  property p_tbl_rd;
    table_read_q |=> s_quiet(table_read_q);
  endproperty
  a_tbl_rd: assert property (p_tbl_rd) else $error("table read pulses too close");
  property p_tbl_wr;
    table_write_q |=> s_quiet(table_write_q);
  endproperty
  a_tbl_wr: assert property (p_tbl_wr) else $error("table write pulses too close");
  property p_ret;
    return_pop_q |=> s_quiet(return_pop_q);
  endproperty
  a_ret: assert property (p_ret) else $error("return pulses too close");
  property p_presc;
    prescaler_clear_q |-> $past(prescaler_to_timer && file_is_timer_zero);
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler cleared without cause");
  property p_indexed;
    (phase == 2'h1) && file_raddr_indexed_q |-> $past(ext_set_en);
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed mode without extended set");
endmodule

// [verification/laldec_mem_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Data memory seen by the core
// ----------------------------------------------------------------
module laldec_mem_model (
  input wire clock,
  input wire [11:0] file_raddr_q,
  input wire file_we_q,
  input wire [11:0] file_waddr_q,
  input wire [7:0] file_wdata_q,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [0:255];
  // Each byte starts as its address mixed with a pattern; only the low byte decodes.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'hA5;
    end
  end
  // Writes land on the edge that carries the strobe.
  always @(posedge clock) begin
    if (file_we_q === 1'b1) begin
      mem[file_waddr_q[7:0]] <= file_wdata_q;
    end
  end
  assign file_rdata = mem[file_raddr_q[7:0]];
endmodule

// [verification/tb_laldec_core.sv]
`timescale 1ns/1ps
`include "laldec_map.vh"
module tb_laldec_core;
  logic clock, srst, ext_set_en, file_is_port, file_is_timer_zero, prescaler_to_timer;
  logic [15:0] instr_word;
  logic [7:0] file_rdata, acc, fd, we_d;
  logic [1:0] phase;
  logic fetch_next_q, file_raddr_indexed_q, file_we_q, table_read_q, table_write_q, return_pop_q, prescaler_clear_q;
  logic [11:0] file_raddr_q, file_waddr_q, fsp0, fsp1, fsp2, we_a, ra;
  logic ri;
  logic [7:0] file_wdata_q;
  logic [4:0] status_flags_q;
  logic [3:0] bank_select_reg_q;
  logic [15:0] product_q;
  logic [20:0] table_ptr_q, tp;
  int errors, checked, n_rd, n_wr, n_ret, n_pc, n_we;
  logic [15:0] lw [0:9] = '{16'h0E7F, 16'h0F01, 16'h0B00, 16'h0980, 16'h0A80, 16'h0E01, 16'h0800, 16'h0E10,
    16'h0D12, 16'h0105};
  logic [7:0] la [0:9] = '{8'h7F, 8'h80, 8'h00, 8'h80, 8'h00, 8'h01, 8'hFF, 8'h10, 8'h10, 8'h10};
  logic [4:0] lf [0:9] = '{5'h00, 5'h1A, 5'h0E, 5'h1A, 5'h0E, 5'h0E, 5'h10, 5'h10, 5'h10, 5'h10};
  laldec_core laldec_core_i (.clock(clock), .srst(srst), .instr_word(instr_word), .ext_set_en(ext_set_en),
    .file_rdata(file_rdata), .file_is_port(file_is_port), .port_pins(8'h3C), .file_is_timer_zero(file_is_timer_zero),
    .prescaler_to_timer(prescaler_to_timer), .index_base(8'h40), .phase(phase), .fetch_next_q(fetch_next_q),
    .file_raddr_q(file_raddr_q), .file_raddr_indexed_q(file_raddr_indexed_q), .file_we_q(file_we_q),
    .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q), .working_accumulator_q(acc),
    .status_flags_q(status_flags_q), .bank_select_reg_q(bank_select_reg_q), .product_q(product_q),
    .file_select_pointer0_q(fsp0), .file_select_pointer1_q(fsp1), .file_select_pointer2_q(fsp2),
    .table_ptr_q(table_ptr_q), .table_read_q(table_read_q), .table_write_q(table_write_q),
    .return_pop_q(return_pop_q), .prescaler_clear_q(prescaler_clear_q));
  laldec_mem_model laldec_mem_model_i (.clock(clock), .file_raddr_q(file_raddr_q), .file_we_q(file_we_q),
    .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q), .file_rdata(file_rdata));
  // ----------------------------------------------------------------
  // Clock, pulse counters and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Pulses are counted here so that no check depends on their exact clock.
  always @(posedge clock) begin
    if (table_read_q === 1'b1) n_rd++;
    if (table_write_q === 1'b1) n_wr++;
    if (return_pop_q === 1'b1) n_ret++;
    if (prescaler_clear_q === 1'b1) n_pc++;
    // The address still belongs to the finished op while its fetch pulse stands.
    if (fetch_next_q === 1'b1) begin
      ra = file_raddr_q;
      ri = file_raddr_indexed_q;
    end
    if (file_we_q === 1'b1) begin
      n_we++;
      we_a = file_waddr_q;
      we_d = file_wdata_q;
    end
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [20:0] exp, input logic [20:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // A word is launched on the edge that ends phase 3, so it is stable for the whole next cycle.
  task automatic put(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clock);
    while (phase !== 2'h3) begin
      n++;
      if (n > 8) begin
        errors++;
        close_out();
      end
      @(negedge clock);
    end
    @(posedge clock);
    instr_word <= w;
  endtask
  // Two extra clocks let pulses registered on the answer edge reach the counters.
  task automatic run2(input logic [15:0] w1, input logic [15:0] w2, input logic two);
    n_rd = 0;
    n_wr = 0;
    n_ret = 0;
    n_pc = 0;
    n_we = 0;
    put(w1);
    if (two) put(w2);
    put(16'h0000);
    repeat (2) @(negedge clock);
  endtask
  task automatic lv(input logic e, input logic p, input logic t, input logic s);
    @(posedge clock);
    ext_set_en <= e;
    file_is_port <= p;
    file_is_timer_zero <= t;
    prescaler_to_timer <= s;
  endtask
  function automatic logic [4:0] addf(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    addf = {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    instr_word = 16'h0000;
    {ext_set_en, file_is_port, file_is_timer_zero, prescaler_to_timer} = 4'h0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    chk("acc", `LALDEC_ACC_RESET, acc);
    chk("ptr", `LALDEC_TBLPTR_RESET, table_ptr_q);
    for (int i = 0; i < 10; i++) begin
      run2(lw[i], 16'h0000, 1'b0);
      chk("acc", la[i], acc);
      chk("flags", lf[i], status_flags_q);
    end
    chk("product", 16'h0120, product_q);
    chk("bank", 4'h5, bank_select_reg_q);
    run2(16'h0C42, 16'h0F01, 1'b1);
    chk("acc", 8'h42, acc);
    chk("pops", 1, n_ret);
    chk("flags", 5'h10, status_flags_q);
    for (int f = 0; f < 3; f++) begin
      run2(16'hEE00 | (f << 4) | (3 + f), 16'hF05A + f, 1'b1);
    end
    chk("fsp0", 12'h35A, fsp0);
    chk("fsp1", 12'h45B, fsp1);
    chk("fsp2", 12'h55C, fsp2);
    run2(16'hF00F, 16'h0000, 1'b0);
    chk("acc", 8'h42, acc);
    tp = 21'h000000;
    for (int c = 8; c < 16; c++) begin
      run2(c[15:0], 16'h0F01, 1'b1);
      if (c[1:0] == 2'h2) tp = tp - 21'h1;
      else if (c[0]) tp = tp + 21'h1;
      chk("ptr", tp, table_ptr_q);
      chk("reads", c < 12, n_rd);
      chk("writes", c >= 12, n_wr);
      chk("acc", 8'h42, acc);
    end
    run2(16'h2520, 16'h0000, 1'b0);
    chk("raddr", 12'h520, ra);
    chk("acc", 8'hC7, acc);
    chk("flags", addf(8'h42, 8'h85), status_flags_q);
    chk("we", 0, n_we);
    run2(16'h2690, 16'h0000, 1'b0);
    chk("raddr", 12'hF90, ra);
    chk("acc", 8'hC7, acc);
    chk("we", 1, n_we);
    chk("waddr", 12'hF90, we_a);
    chk("wdata", 8'hFC, we_d);
    lv(1'b1, 1'b0, 1'b0, 1'b0);
    run2(16'h2460, 16'h0000, 1'b0);
    chk("indexed", 0, ri);
    chk("acc", 8'h8C, acc);
    run2(16'h245F, 16'h0000, 1'b0);
    chk("indexed", 1, ri);
    lv(1'b0, 1'b1, 1'b0, 1'b0);
    run2(16'h0E10, 16'h2521, 1'b1);
    chk("acc", 8'h4C, acc);
    run2(16'h2521, 16'h0000, 1'b0);
    chk("acc", 8'h88, acc);
    lv(1'b0, 1'b0, 1'b1, 1'b1);
    run2(16'h2722, 16'h0000, 1'b0);
    chk("clears", 1, n_pc);
    lv(1'b0, 1'b0, 1'b1, 1'b0);
    run2(16'h2722, 16'h0000, 1'b0);
    chk("clears", 0, n_pc);
    close_out();
  end
endmodule
bind laldec_core laldec_core_chk laldec_core_chk_i (.clock(clock), .srst(srst), .ext_set_en(ext_set_en),
  .file_is_timer_zero(file_is_timer_zero), .prescaler_to_timer(prescaler_to_timer), .phase(phase),
  .fetch_next_q(fetch_next_q), .file_raddr_indexed_q(file_raddr_indexed_q), .file_we_q(file_we_q),
  .working_accumulator_q(working_accumulator_q), .status_flags_q(status_flags_q), .table_read_q(table_read_q),
  .table_write_q(table_write_q), .return_pop_q(return_pop_q), .prescaler_clear_q(prescaler_clear_q));
